// File: hw/boi_bit_op_unit.sv
// Notes on behaviour
// - Opcode 0101 sets bit, one cycle.
// - Opcode 0111 skips next when bit set.
// - Opcode 0110 skips next when bit clear.
// - Skip replaces prefetched word with no-operation.
// - Bit field 7:5, address field 4:0.
module boi_bit_op_unit
   import boi_pkg::*;
(
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic                       instr_valid,
   input  wire logic [boi_pkg::INSTR_W-1:0] instr,
   output logic                            exec_valid_q,
   output logic      [boi_pkg::INSTR_W-1:0] exec_instr_q,
   output logic                            skip_q,
   output logic                            set_done_q,
   output logic      [boi_pkg::ADDR_W-1:0]  last_addr_q,
   output logic      [boi_pkg::DATA_W-1:0]  last_data_q
);
   import boi_pkg::*;

   boi_state_t            state_q;
   boi_state_t            state_d;
   logic [DATA_W-1:0]     rd_data;
   logic [DATA_W-1:0]     bit_mask;
   logic [DATA_W-1:0]     set_value;
   logic                  sel_bit;

   wire [3:0]          opcode = instr[OPC_MSB:OPC_LSB];
   wire [BITSEL_W-1:0] bitsel = instr[BITSEL_MSB:BITSEL_LSB];
   wire [ADDR_W-1:0]   faddr  = instr[ADDR_MSB:ADDR_LSB];

   // discard the word after a taken skip
   wire live       = instr_valid && state_q == BOI_RUN;
   wire is_set     = live && opcode == OPC_SET;
   wire is_tst_set = live && opcode == OPC_SKIP_SET;
   wire is_tst_clr = live && opcode == OPC_SKIP_CLEAR;

   assign bit_mask  = DATA_W'(1) << bitsel;
   assign set_value = rd_data | bit_mask;
   assign sel_bit   = rd_data[bitsel];

   // skip on set; skip on clear
   wire take_skip = (is_tst_set && sel_bit) || (is_tst_clr && !sel_bit);

   assign state_d = take_skip ? BOI_SKIP : (instr_valid ? BOI_RUN : state_q);

   boi_file_regs u_file (
      .core_clk (core_clk),
      .rst      (rst),
      .addr     (faddr),
      .wr_en    (is_set),
      .wr_data  (set_value),
      .rd_data  (rd_data)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q      <= BOI_RUN;
         exec_valid_q <= 1'b0;
         exec_instr_q <= NO_OPERATION;
         skip_q       <= 1'b0;
         set_done_q   <= 1'b0;
         last_addr_q  <= '0;
         last_data_q  <= FILE_RESET;
      end else begin
         state_q      <= state_d;
         exec_valid_q <= instr_valid;
         // no-operation in place of skipped word
         exec_instr_q <= live ? instr : NO_OPERATION;
         skip_q       <= take_skip;
         set_done_q   <= is_set;
         if (live) begin
            last_addr_q <= faddr;
            last_data_q <= is_set ? set_value : rd_data;
         end
      end
   end

   a_set_bit_one: assert property (@(posedge core_clk) disable iff (rst)
      is_set |=> set_done_q && last_data_q == $past(set_value))
      else $error("bit set result wrong");

   a_skip_if_set: assert property (@(posedge core_clk) disable iff (rst)
      (is_tst_set && sel_bit) |=> skip_q)
      else $error("skip on set missed");

   a_skip_if_clr: assert property (@(posedge core_clk) disable iff (rst)
      (is_tst_clr && !sel_bit) |=> skip_q)
      else $error("skip on clear missed");

   a_skip_nop_next: assert property (@(posedge core_clk) disable iff (rst)
      (take_skip ##1 instr_valid) |=> exec_instr_q == NO_OPERATION && !skip_q && !set_done_q)
      else $error("skipped word executed");

   a_skip_cause: assert property (@(posedge core_clk) disable iff (rst)
      skip_q |-> $past(is_tst_set || is_tst_clr))
      else $error("spurious skip");

   a_addr_field: assert property (@(posedge core_clk) disable iff (rst)
      live |=> last_addr_q == $past(faddr))
      else $error("address field wrong");

   a_rmw_keep: assert property (@(posedge core_clk) disable iff (rst)
      is_set |=> (last_data_q & ~$past(bit_mask)) == ($past(rd_data) & ~$past(bit_mask)))
      else $error("other bits disturbed");

   a_set_visible: assert property (@(posedge core_clk) disable iff (rst)
      is_set ##1 (instr_valid && faddr == $past(faddr)) |-> rd_data[$past(bitsel)])
      else $error("bit not stored");

   a_reset_outputs: assert property (@(posedge core_clk)
      rst |=> !exec_valid_q && !skip_q && !set_done_q && exec_instr_q == NO_OPERATION)
      else $error("outputs not cleared by reset");

   a_reset_state: assert property (@(posedge core_clk)
      rst |=> state_q == BOI_RUN && last_data_q == FILE_RESET)
      else $error("state not cleared by reset");

   a_noskip_set_op: assert property (@(posedge core_clk) disable iff (rst)
      (is_tst_set && !sel_bit) |=> !skip_q)
      else $error("skip on set taken wrongly");

   a_noskip_clr_op: assert property (@(posedge core_clk) disable iff (rst)
      (is_tst_clr && sel_bit) |=> !skip_q)
      else $error("skip on clear taken wrongly");

   a_set_no_skip: assert property (@(posedge core_clk) disable iff (rst)
      is_set |=> !skip_q)
      else $error("set caused a skip");

   a_set_pulse_src: assert property (@(posedge core_clk) disable iff (rst)
      set_done_q |-> $past(is_set))
      else $error("spurious set pulse");

   a_exec_copy: assert property (@(posedge core_clk) disable iff (rst)
      live |=> exec_instr_q == $past(instr))
      else $error("executed word wrong");

   a_valid_high: assert property (@(posedge core_clk) disable iff (rst)
      instr_valid |=> exec_valid_q)
      else $error("valid copy lost");

   a_valid_low: assert property (@(posedge core_clk) disable iff (rst)
      !instr_valid |=> !exec_valid_q)
      else $error("valid copy spurious");

   a_skip_enters: assert property (@(posedge core_clk) disable iff (rst)
      take_skip |=> state_q == BOI_SKIP)
      else $error("skip state not entered");

   a_skip_pending: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == BOI_SKIP && !instr_valid) |=> state_q == BOI_SKIP)
      else $error("pending skip lost");

   a_skip_release: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == BOI_SKIP && instr_valid) |=> state_q == BOI_RUN)
      else $error("skip state stuck");

   // no skip from a discarded word
   a_skip_single: assert property (@(posedge core_clk) disable iff (rst)
      skip_q |-> !take_skip)
      else $error("skip chained");

   a_skip_no_effect: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == BOI_SKIP && instr_valid) |=> !set_done_q && exec_instr_q == NO_OPERATION)
      else $error("discarded word acted");

   a_set_bit_high: assert property (@(posedge core_clk) disable iff (rst)
      is_set |=> last_data_q[$past(bitsel)])
      else $error("selected bit not high");

   a_test_reads: assert property (@(posedge core_clk) disable iff (rst)
      (is_tst_set || is_tst_clr) |=> last_data_q == $past(rd_data))
      else $error("test data wrong");

   a_test_no_done: assert property (@(posedge core_clk) disable iff (rst)
      (is_tst_set || is_tst_clr) |=> !set_done_q)
      else $error("test caused a write");

   a_idle_hold: assert property (@(posedge core_clk) disable iff (rst)
      !live |=> $stable(last_addr_q) && $stable(last_data_q))
      else $error("last values moved");

   a_mask_onehot: assert property (@(posedge core_clk) disable iff (rst)
      $onehot(bit_mask))
      else $error("bit mask not one-hot");

   a_other_ops: assert property (@(posedge core_clk) disable iff (rst)
      (live && opcode != OPC_SET && opcode != OPC_SKIP_SET && opcode != OPC_SKIP_CLEAR) |=> !skip_q && !set_done_q)
      else $error("unknown opcode acted");
endmodule // boi_bit_op_unit

// File: hw/boi_pkg.sv
package boi_pkg;
   localparam int          INSTR_W        = 12;
   localparam int          DATA_W         = 8;
   localparam int          ADDR_W         = 5;
   localparam int          BITSEL_W       = 3;
   localparam int          OPC_MSB        = 11;
   localparam int          OPC_LSB        = 8;
   localparam int          BITSEL_MSB     = 7;
   localparam int          BITSEL_LSB     = 5;
   localparam int          ADDR_MSB       = 4;
   localparam int          ADDR_LSB       = 0;
   localparam logic [3:0]  OPC_SET        = 4'h5;
   localparam logic [3:0]  OPC_SKIP_CLEAR = 4'h6;
   localparam logic [3:0]  OPC_SKIP_SET   = 4'h7;
   localparam logic [11:0] NO_OPERATION   = 12'h000;
   localparam logic [7:0]  FILE_RESET     = 8'h00;
   localparam int          FILE_DEPTH     = 32;

   typedef enum logic [1:0] {
      BOI_RUN  = 2'b00,
      BOI_SKIP = 2'b01
   } boi_state_t;
endpackage

// File: hw/boi_file_regs.sv
module boi_file_regs
   import boi_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   input  wire logic [boi_pkg::ADDR_W-1:0] addr,
   input  wire logic                    wr_en,
   input  wire logic [boi_pkg::DATA_W-1:0] wr_data,
   output logic      [boi_pkg::DATA_W-1:0] rd_data
);
   logic [DATA_W-1:0] mem_q [FILE_DEPTH];

   assign rd_data = mem_q[addr];

   genvar gi;
   generate
      for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_reg
         always_ff @(posedge core_clk) begin
            if (rst) begin
               mem_q[gi] <= FILE_RESET;
            end else if (wr_en && addr == ADDR_W'(gi)) begin
               mem_q[gi] <= wr_data;
            end
         end
      end
   endgenerate
endmodule // boi_file_regs

// File: dv/boi_fetch_model.sv
module boi_fetch_model
   import boi_pkg::*;
(
   input  wire logic                        core_clk,
   output logic                             instr_valid,
   output logic      [boi_pkg::INSTR_W-1:0] instr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      instr_valid = 1'b0;
      instr       = 12'h000;
   end
   // Idle word flips so stale data is never trusted
   task automatic send(input logic [11:0] w, input logic v);
      instr_valid = v;
      instr       = v ? w : ~instr;
      @(posedge core_clk);
      #1;
   endtask
endmodule // boi_fetch_model

// File: dv/boi_bit_op_unit_tb.sv
module boi_bit_op_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import boi_pkg::*;
   logic               core_clk, rst, instr_valid, exec_valid_q, skip_q, set_done_q;
   logic [INSTR_W-1:0] instr, exec_instr_q;
   logic [ADDR_W-1:0]  last_addr_q;
   logic [DATA_W-1:0]  last_data_q;
   int                 bad_count = 0;
   int                 samples_checked = 0;
   boi_bit_op_unit boi_bit_op_unit_inst (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
      .instr(instr), .exec_valid_q(exec_valid_q), .exec_instr_q(exec_instr_q), .skip_q(skip_q),
      .set_done_q(set_done_q), .last_addr_q(last_addr_q), .last_data_q(last_data_q));
   boi_fetch_model boi_fetch_model_inst (.core_clk(core_clk), .instr_valid(instr_valid), .instr(instr));
   task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic go(input logic [11:0] w, input logic v = 1'b1);
      boi_fetch_model_inst.send(w, v);
   endtask
   task automatic test_set;
      go(12'h5e3);
      chk("set_done", set_done_q, 12'h001);
      chk("valid", exec_valid_q, 12'h001);
      chk("exec", exec_instr_q, 12'h5e3);
      chk("addr", last_addr_q, 12'h003);
      chk("data", last_data_q, 12'h080);
      go(12'h503);
      chk("data", last_data_q, 12'h081);
      go(12'h5ff);
      chk("addr", last_addr_q, 12'h01f);
      chk("data", last_data_q, 12'h080);
      go(12'h000, 1'b0);
      chk("set_done", set_done_q, 12'h000);
      chk("valid", exec_valid_q, 12'h000);
   endtask
   task automatic test_skip_set;
      go(12'h7e3);
      chk("skip", skip_q, 12'h001);
      go(12'h523);
      chk("exec", exec_instr_q, NO_OPERATION);
      chk("set_done", set_done_q, 12'h000);
      go(12'h603);
      chk("skip", skip_q, 12'h000);
      chk("data", last_data_q, 12'h081);
   endtask
   task automatic test_skip_clear;
      go(12'h6a5);
      chk("skip", skip_q, 12'h001);
      go(12'h7a5);
      chk("exec", exec_instr_q, NO_OPERATION);
      go(12'h7a5);
      chk("skip", skip_q, 12'h000);
      go(12'h000, 1'b0);
   endtask
   task automatic test_skip_pending;
      go(12'h7e3);
      chk("skip", skip_q, 12'h001);
      go(12'h000, 1'b0);
      chk("skip", skip_q, 12'h000);
      go(12'h5a5);
      chk("exec", exec_instr_q, NO_OPERATION);
      chk("set_done", set_done_q, 12'h000);
      go(12'h6a5);
      chk("skip", skip_q, 12'h001);
      go(12'h000, 1'b0);
   endtask
   task automatic test_mid_reset;
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 rst = 1'b0;
      chk("skip", skip_q, 12'h000);
      chk("exec", exec_instr_q, NO_OPERATION);
      chk("data", last_data_q, 12'h000);
      go(12'h5a5);
      chk("set_done", set_done_q, 12'h001);
      chk("data", last_data_q, 12'h020);
      go(12'h6e3);
      chk("skip", skip_q, 12'h001);
      chk("data", last_data_q, 12'h000);
      go(12'h000, 1'b0);
   endtask
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      repeat (5) @(posedge core_clk);
      #1 rst = 1'b0;
      test_set();
      test_skip_set();
      test_skip_clear();
      test_skip_pending();
      test_mid_reset();
      report_and_stop();
   end
endmodule // boi_bit_op_unit_tb
